// File: downstream_port_strap_led_logic.sv
// Downstream port power enables, indicator lights and reset-time straps
//
// Overview of operation
// - One power enable per port, strap polarity
// - Status lights of ports 5-7 active low
// - Loaded config with lights: ports 3-4 low
// - Default config samples port-disable code at release
// - Disable code turns off ports 7, 6, 5
// - Disable code bits set ports 4/3 polarity
// - Loaded config with lights: ports 1-2 low
// - Default config samples fixed-device code at release
// - Fixed code marks ports 1, 2, 3 fixed
// - Fixed code bits set ports 2/1 polarity
// - Alert lights of ports 5-7 active low
// - Polarity strap latched at reset release
// - Power held inactive from strap during reset
`timescale 1ns/100ps
module downstream_port_strap_led_logic (
    input  wire logic                                   REF_CLK,
    input  wire logic                                   RSTN,
    input  wire logic                                   CE,
    input  wire logic [strap_led_pkg::ADDR_W-1:0]       REG_ADDR,
    input  wire logic [strap_led_pkg::DATA_W-1:0]       REG_WDATA,
    input  wire logic                                   REG_WR,
    input  wire logic                                   REG_RD,
    output logic      [strap_led_pkg::DATA_W-1:0]       REG_RDATA,
    input  wire logic [strap_led_pkg::LAST_PORT:1]      PORT_POWER_REQ,
    input  wire logic [strap_led_pkg::LAST_PORT:1]      STATUS_LIGHT_REQ,
    input  wire logic [strap_led_pkg::LAST_PORT:5]      ALERT_LIGHT_REQ,
    input  wire logic                                   POWER_ENABLE_POLARITY_STRAP,
    input  wire logic [4:1]                             PORT_STATUS_LIGHT_IN,
    output logic      [strap_led_pkg::LAST_PORT:1]      PORT_STATUS_LIGHT_OUT,
    output logic      [strap_led_pkg::LAST_PORT:1]      PORT_STATUS_LIGHT_OE,
    output logic      [strap_led_pkg::LAST_PORT:5]      PORT_ALERT_LIGHT_OUT,
    output logic      [strap_led_pkg::LAST_PORT:1]      PORT_POWER_ENABLE,
    output logic      [strap_led_pkg::LAST_PORT:1]      PORT_ENABLED,
    output logic      [strap_led_pkg::LAST_PORT:1]      PORT_FIXED
);
    import strap_led_pkg::*;

    // Pin level that lights a lamp of the given polarity
    function automatic logic light_level(input logic on, input logic act_low);
        light_level = on ^ act_low;
    endfunction

    // Port-disable code to mask of ports left enabled
    function automatic logic [LAST_PORT:1] enable_mask(input logic [1:0] code);
        logic [LAST_PORT:1] m;
        m = 7'h7F;
        case (code)
            2'h0:    m = 7'h7F;                         // All ports enabled
            2'h1:    m = 7'h3F;                         // Port 7 off
            2'h2:    m = 7'h1F;                         // Ports 7, 6 off
            2'h3:    m = 7'h0F;                         // Ports 7, 6, 5 off
            default: m = 7'h7F;
        endcase
        enable_mask = m;
    endfunction

    // Fixed-device code to mask of non-removable ports
    function automatic logic [LAST_PORT:1] fixed_mask(input logic [1:0] code);
        logic [LAST_PORT:1] m;
        m = 7'h00;
        case (code)
            2'h0:    m = 7'h00;                         // All removable
            2'h1:    m = 7'h01;                         // Port 1 fixed
            2'h2:    m = 7'h03;                         // Ports 1, 2 fixed
            2'h3:    m = 7'h07;                         // Ports 1, 2, 3 fixed
            default: m = 7'h00;
        endcase
        fixed_mask = m;
    endfunction

    // Synchronised pins: bit 4 polarity strap, bits 3:0 shared light pins 4..1
    logic [4:0]          pins_sync;
    logic                pol_pin;                       // Polarity strap after two flops
    logic [4:1]          light_pin;                     // Shared light pins after two flops

    strap_pin_sync #(
        .WIDTH    (5)
    ) u_pin_sync (
        .clk      (REF_CLK),
        .ce       (CE),
        .pin      ({POWER_ENABLE_POLARITY_STRAP, PORT_STATUS_LIGHT_IN}),
        .pin_sync (pins_sync)
    );

    assign pol_pin   = pins_sync[4];
    assign light_pin = pins_sync[3:0];

    // Captured strap state
    logic                pol_ff;                        // Latched power polarity, 1 = high
    logic [1:0]          dis_code_ff;                   // Port-disable code {port4, port3}
    logic [1:0]          fix_code_ff;                   // Fixed-device code {port2, port1}
    logic                nxt_pol;
    logic [1:0]          nxt_dis_code;
    logic [1:0]          nxt_fix_code;

    // Control and bus state
    phase_type           phase_ff;                      // Strap or run phase
    phase_type           nxt_phase;
    logic                loaded_ff;                     // Configuration loaded from memory/bus
    logic                lights_ff;                     // Loaded configuration enables lights
    logic [DATA_W-1:0]   rdata_ff;                      // Read data, valid one cycle
    logic                nxt_loaded;
    logic                nxt_lights;
    logic [DATA_W-1:0]   nxt_rdata;

    // Pin drive state
    logic [LAST_PORT:1]  pwr_ff;                        // Power enable pin levels
    logic [LAST_PORT:1]  st_out_ff;                     // Status light pin levels
    logic [LAST_PORT:1]  st_oe_ff;                      // Status light drive enables
    logic [LAST_PORT:5]  al_out_ff;                     // Alert light pin levels
    logic [LAST_PORT:1]  en_ff;                         // Ports left enabled
    logic [LAST_PORT:1]  fixm_ff;                       // Ports marked non-removable
    logic [LAST_PORT:1]  nxt_pwr;
    logic [LAST_PORT:1]  nxt_st_out;
    logic [LAST_PORT:1]  nxt_st_oe;
    logic [LAST_PORT:5]  nxt_al_out;
    logic [LAST_PORT:1]  nxt_en;
    logic [LAST_PORT:1]  nxt_fixm;

    // Per-port status light polarity, 1 = active low
    logic [LAST_PORT:1]  st_act_low;
    logic [LAST_PORT:1]  st_drive;                      // Status pins driven in run phase
    logic [LAST_PORT:1]  eff_en;                        // Enable mask in force now

    // Strap capture: follows the pins while reset is held, frozen after.
    // Sampling the last reset cycle gives the value present at release.
    always_comb begin
        nxt_pol      = pol_ff;
        nxt_dis_code = dis_code_ff;
        nxt_fix_code = fix_code_ff;
        if (!RSTN) begin
            nxt_pol      = pol_pin;
            nxt_dis_code = {light_pin[4], light_pin[3]};
            nxt_fix_code = {light_pin[2], light_pin[1]};
        end else begin
            // Held until the next hardware reset
            nxt_pol      = pol_ff;
            nxt_dis_code = dis_code_ff;
            nxt_fix_code = fix_code_ff;
        end
    end

    // Strap registers; no constant reset since they are loaded in reset
    always_ff @(posedge REF_CLK) begin
        if (CE) begin
            pol_ff      <= nxt_pol;
            dis_code_ff <= nxt_dis_code;
            fix_code_ff <= nxt_fix_code;
        end
    end

    // Phase and register bus next values
    always_comb begin
        nxt_phase  = phase_ff;
        nxt_loaded = loaded_ff;
        nxt_lights = lights_ff;
        nxt_rdata  = RDATA_RST;                         // Data only in the cycle after a read
        case (phase_ff)
            PH_STRAP: nxt_phase = PH_RUN;               // First edge after release
            PH_RUN:   nxt_phase = PH_RUN;
            default:  nxt_phase = PH_STRAP;
        endcase
        // Write to control register; other offsets ignored
        if (REG_WR && (REG_ADDR == REG_CTRL_OFS)) begin
            nxt_loaded = REG_WDATA[CTRL_LOADED_BIT];
            nxt_lights = REG_WDATA[CTRL_LIGHTS_BIT];
        end
        // Read mux; unmapped offsets read zero
        if (REG_RD) begin
            case (REG_ADDR)
                REG_CTRL_OFS: begin
                    nxt_rdata[CTRL_LOADED_BIT] = loaded_ff;
                    nxt_rdata[CTRL_LIGHTS_BIT] = lights_ff;
                end
                REG_STAT_OFS: begin
                    nxt_rdata[STAT_DIS_LSB +: 2]  = dis_code_ff;
                    nxt_rdata[STAT_FIX_LSB +: 2]  = fix_code_ff;
                    nxt_rdata[STAT_POL_BIT]       = pol_ff;
                    nxt_rdata[STAT_PWR_LSB +: 7]  = pwr_ff;
                    nxt_rdata[STAT_EN_LSB +: 7]   = en_ff;
                    nxt_rdata[STAT_FIXM_LSB +: 7] = fixm_ff;
                end
                default: nxt_rdata = RDATA_RST;
            endcase
        end
    end

    // Phase and bus registers with synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (CE) begin
            if (!RSTN) begin
                phase_ff  <= PH_STRAP;
                loaded_ff <= CTRL_LOADED_RST;
                lights_ff <= CTRL_LIGHTS_RST;
                rdata_ff  <= RDATA_RST;
            end else begin
                phase_ff  <= nxt_phase;
                loaded_ff <= nxt_loaded;
                lights_ff <= nxt_lights;
                rdata_ff  <= nxt_rdata;
            end
        end
    end

    // Light polarity and drive selection.
    // The disable and fixed codes only steer the hub under the default
    // configuration; a loaded configuration carries its own port setup.
    always_comb begin
        st_act_low = 7'h7F;
        st_drive   = 7'h7F;
        eff_en     = 7'h7F;
        // Ports 5..7 are always active low and driven throughout the run phase
        st_act_low[LAST_PORT:FIRST_FIXED_LOW] = 3'h7;
        if (loaded_ff) begin
            // Lights on the shared pins only when the configuration asks
            st_act_low[4:3] = 2'h3;
            st_act_low[2:1] = 2'h3;
            st_drive[4:1]   = {4{lights_ff}};
        end else begin
            // Each strap bit that read 1 makes its light active low
            st_act_low[4] = dis_code_ff[1];
            st_act_low[3] = dis_code_ff[0];
            st_act_low[2] = fix_code_ff[1];
            st_act_low[1] = fix_code_ff[0];
            eff_en        = en_ff;
        end
    end

    // Pin drive next values
    always_comb begin
        nxt_pwr    = pwr_ff;
        nxt_st_out = st_out_ff;
        nxt_st_oe  = st_oe_ff;
        nxt_al_out = al_out_ff;
        nxt_en     = enable_mask(dis_code_ff);
        nxt_fixm   = fixed_mask(fix_code_ff);
        if (!RSTN || (phase_ff == PH_STRAP)) begin
            // Power held at the inactive level of the live strap pin.
            // The pin passes two flops first, so the first two reset
            // cycles after power-up may still show an unsettled level.
            nxt_pwr    = {LAST_PORT{~pol_pin}};
            nxt_st_out = 7'h7F;
            nxt_st_oe  = 7'h00;                         // Release shared pins to the straps
            nxt_al_out = 3'h7;                          // Dark, active low
        end else begin
            for (int p = 1; p <= LAST_PORT; p++) begin
                // Under the default configuration, disabled ports never get power, whatever is requested
                nxt_pwr[p]    = light_level(PORT_POWER_REQ[p] & eff_en[p], ~pol_ff);
                nxt_st_out[p] = light_level(STATUS_LIGHT_REQ[p] & eff_en[p],
                                            st_act_low[p]);
                nxt_st_oe[p]  = st_drive[p];
            end
            for (int p = FIRST_FIXED_LOW; p <= LAST_PORT; p++) begin
                nxt_al_out[p] = light_level(ALERT_LIGHT_REQ[p] & eff_en[p], 1'b1);
            end
        end
    end

    // Pin drive registers
    always_ff @(posedge REF_CLK) begin
        if (CE) begin
            pwr_ff    <= nxt_pwr;
            st_out_ff <= nxt_st_out;
            st_oe_ff  <= nxt_st_oe;
            al_out_ff <= nxt_al_out;
            en_ff     <= nxt_en;
            fixm_ff   <= nxt_fixm;
        end
    end

    // Outputs straight from flops
    assign REG_RDATA             = rdata_ff;
    assign PORT_POWER_ENABLE     = pwr_ff;
    assign PORT_STATUS_LIGHT_OUT = st_out_ff;
    assign PORT_STATUS_LIGHT_OE  = st_oe_ff;
    assign PORT_ALERT_LIGHT_OUT  = al_out_ff;
    assign PORT_ENABLED          = en_ff;
    assign PORT_FIXED            = fixm_ff;
endmodule // downstream_port_strap_led_logic

// File: strap_led_pkg.sv
// Shared constants and types for the downstream port strap and light logic
package strap_led_pkg;
    // Port numbering
    localparam int unsigned LAST_PORT        = 7;       // Highest downstream port
    localparam int unsigned FIRST_FIXED_LOW  = 5;       // Ports from here up have fixed low lights
    // Register bus geometry
    localparam int unsigned ADDR_W           = 4;       // Byte address width
    localparam int unsigned DATA_W           = 32;      // Data width
    // Register offsets (byte addresses)
    localparam logic [3:0]  REG_CTRL_OFS     = 4'h0;    // Configuration source and light enable
    localparam logic [3:0]  REG_STAT_OFS     = 4'h4;    // Captured straps and pin state
    // Control register fields
    localparam int unsigned CTRL_LOADED_BIT  = 0;       // 1: configuration came from memory or bus
    localparam int unsigned CTRL_LIGHTS_BIT  = 1;       // 1: loaded configuration enables lights
    localparam logic        CTRL_LOADED_RST  = 1'h0;    // Default configuration after reset
    localparam logic        CTRL_LIGHTS_RST  = 1'h0;    // Lights off in loaded mode after reset
    // Status register fields
    localparam int unsigned STAT_DIS_LSB     = 0;       // Port-disable code, 2 bits
    localparam int unsigned STAT_FIX_LSB     = 2;       // Fixed-device code, 2 bits
    localparam int unsigned STAT_POL_BIT     = 4;       // Latched power polarity
    localparam int unsigned STAT_PWR_LSB     = 8;       // Power enable pins, 7 bits
    localparam int unsigned STAT_EN_LSB      = 16;      // Enabled port mask, 7 bits
    localparam int unsigned STAT_FIXM_LSB    = 24;      // Fixed port mask, 7 bits
    // Reset values of captured state and outputs
    localparam logic [1:0]  CODE_RST         = 2'h0;    // Strap codes before first capture
    localparam logic        POL_RST          = 1'h0;    // Polarity before first capture
    localparam logic [31:0] RDATA_RST        = 32'h0000_0000;
    // Synchroniser depth
    localparam int unsigned SYNC_STAGES      = 2;       // Flops on every pin input
    // Strap phase
    typedef enum logic {
        PH_STRAP,                                       // Reset held, pins are straps
        PH_RUN                                          // Straps captured, pins are lights
    } phase_type;
endpackage

// File: strap_pin_sync.sv
// Two-stage synchroniser for pin inputs, with clock enable
`timescale 1ns/100ps
module strap_pin_sync #(
    parameter int unsigned WIDTH = 1                    // Number of pins carried
) (
    input  wire logic             clk,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] pin_sync
);
    import strap_led_pkg::*;

    // Width check at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("strap_pin_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta_ff;                          // First stage, read only by second
    logic [WIDTH-1:0] stable_ff;                        // Second stage, safe to use
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_stable;

    // No reset here: the straps must be visible while reset is held
    always_comb begin
        nxt_meta   = pin;
        nxt_stable = meta_ff;
    end

    // Stages freeze with the rest of the block
    always_ff @(posedge clk) begin
        if (ce) begin
            meta_ff   <= nxt_meta;
            stable_ff <= nxt_stable;
        end
    end

    assign pin_sync = stable_ff;
endmodule // strap_pin_sync

// File: strap_led_props.sv
// Assertion checker for the downstream port strap and light logic
`timescale 1ns/100ps
module strap_led_props (
    input wire logic                              REF_CLK,
    input wire logic                              RSTN,
    input wire logic                              CE,
    input wire logic [strap_led_pkg::ADDR_W-1:0]  REG_ADDR,
    input wire logic [strap_led_pkg::DATA_W-1:0]  REG_WDATA,
    input wire logic                              REG_WR,
    input wire logic [strap_led_pkg::LAST_PORT:1] PORT_POWER_REQ,
    input wire logic [strap_led_pkg::LAST_PORT:1] STATUS_LIGHT_REQ,
    input wire logic [strap_led_pkg::LAST_PORT:5] ALERT_LIGHT_REQ,
    input wire logic                              POWER_ENABLE_POLARITY_STRAP,
    input wire logic [4:1]                        PORT_STATUS_LIGHT_IN,
    input wire logic [strap_led_pkg::LAST_PORT:1] PORT_STATUS_LIGHT_OUT,
    input wire logic [strap_led_pkg::LAST_PORT:1] PORT_STATUS_LIGHT_OE,
    input wire logic [strap_led_pkg::LAST_PORT:5] PORT_ALERT_LIGHT_OUT,
    input wire logic [strap_led_pkg::LAST_PORT:1] PORT_POWER_ENABLE,
    input wire logic [strap_led_pkg::LAST_PORT:1] PORT_ENABLED,
    input wire logic [strap_led_pkg::LAST_PORT:1] PORT_FIXED
);
    import strap_led_pkg::*;
    logic [4:0] sync1_ff;   // First sync stage {polarity, pins 4..1}
    logic [4:0] sync2_ff;   // Second sync stage
    logic [4:0] cap_ff;     // Straps as last seen in reset
    logic [1:0] ctrl_ff;    // Mirror of the control bits
    logic [2:0] run_ff;     // Live edges since release, saturating
    logic [7:1] mask_c;     // Ports allowed to act
    // Disable code 0..3 trims ports from the top down
    function automatic logic [7:1] en_of(input logic [1:0] c);
        return 7'h7F >> c;
    endfunction
    // Fixed code 0..3 marks ports from the bottom up
    function automatic logic [7:1] fix_of(input logic [1:0] c);
        return ~(7'h7F << c);
    endfunction
    // Mirror sync and capture so the checker needs no internal probes
    always_ff @(posedge REF_CLK) begin
        if (CE) begin
            sync1_ff <= {POWER_ENABLE_POLARITY_STRAP, PORT_STATUS_LIGHT_IN};
            sync2_ff <= sync1_ff;
        end
        if (CE && !RSTN) begin
            cap_ff  <= sync2_ff;
            ctrl_ff <= 2'h0;
        end else if (CE && REG_WR && REG_ADDR == REG_CTRL_OFS) begin
            ctrl_ff <= REG_WDATA[1:0];
        end
        // A frozen clock restarts the settle count, a cautious trade
        if (!RSTN || !CE) begin
            run_ff <= 3'h0;
        end else if (run_ff != 3'h7) begin
            run_ff <= run_ff + 3'h1;
        end
    end
    // Mask applies only under default configuration
    always_comb mask_c = ctrl_ff[0] ? 7'h7F : en_of(cap_ff[3:2]);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    power_follows_req_a: assert property (run_ff > 3'h2 |-> PORT_POWER_ENABLE ==
        ($past(PORT_POWER_REQ & mask_c) ^ {7{~cap_ff[4]}})) else $error("power level wrong");
    high_status_low_a: assert property (run_ff > 3'h2 |-> PORT_STATUS_LIGHT_OUT[7:5] ==
        ~$past(STATUS_LIGHT_REQ[7:5] & mask_c[7:5])) else $error("status 5-7 level wrong");
    alert_low_a: assert property (run_ff > 3'h2 |-> PORT_ALERT_LIGHT_OUT ==
        ~$past(ALERT_LIGHT_REQ & mask_c[7:5])) else $error("alert level wrong");
    shared_polarity_a: assert property (run_ff > 3'h2 && !$past(ctrl_ff[0]) |->
        PORT_STATUS_LIGHT_OUT[4:1] == ($past(STATUS_LIGHT_REQ[4:1]) ^ cap_ff[3:0]))
        else $error("shared light polarity wrong");
    loaded_lights_a: assert property (run_ff > 3'h2 && $past(ctrl_ff) == 2'h3 |->
        PORT_STATUS_LIGHT_OE[4:1] == 4'hF &&
        PORT_STATUS_LIGHT_OUT[4:1] == ~$past(STATUS_LIGHT_REQ[4:1])) else $error("loaded lights");
    decode_masks_a: assert property (run_ff > 3'h2 |-> PORT_ENABLED == en_of(cap_ff[3:2]) &&
        PORT_FIXED == fix_of(cap_ff[1:0])) else $error("decoded masks wrong");
    codes_held_a: assert property (run_ff > 3'h2 |-> $stable(PORT_ENABLED) && $stable(PORT_FIXED))
        else $error("masks changed in run");
    reset_power_off_a: assert property ($rose(RSTN) |-> PORT_POWER_ENABLE == {7{~cap_ff[4]}} &&
        PORT_STATUS_LIGHT_OE == 7'h00) else $error("power or drive on at release");
    cover property (run_ff > 3'h2 && ctrl_ff == 2'h3);
    cover property (run_ff > 3'h2 && cap_ff[3:2] == 2'h3 && |ALERT_LIGHT_REQ);
    cover property ($rose(RSTN) && cap_ff[4]);
endmodule // strap_led_props

bind downstream_port_strap_led_logic strap_led_props u_props (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .PORT_POWER_REQ(PORT_POWER_REQ), .STATUS_LIGHT_REQ(STATUS_LIGHT_REQ),
    .ALERT_LIGHT_REQ(ALERT_LIGHT_REQ), .POWER_ENABLE_POLARITY_STRAP(POWER_ENABLE_POLARITY_STRAP),
    .PORT_STATUS_LIGHT_IN(PORT_STATUS_LIGHT_IN), .PORT_STATUS_LIGHT_OUT(PORT_STATUS_LIGHT_OUT),
    .PORT_STATUS_LIGHT_OE(PORT_STATUS_LIGHT_OE), .PORT_ALERT_LIGHT_OUT(PORT_ALERT_LIGHT_OUT),
    .PORT_POWER_ENABLE(PORT_POWER_ENABLE), .PORT_ENABLED(PORT_ENABLED), .PORT_FIXED(PORT_FIXED));

// File: light_strap_partner.sv
// Far-side model: strap resistors on the shared light pins and the polarity pin
`timescale 1ns/100ps
module light_strap_partner (
    input  wire logic [4:1] light_out,    // Level the hub drives
    input  wire logic [4:1] light_oe,     // High while the hub drives
    input  wire logic [3:0] strap_code,   // Resistor per pin, {pin4..pin1}
    input  wire logic       pol_sel,      // Resistor on the polarity pin
    output logic      [4:1] pin_level,
    output logic            pol_pin
);
    // A driven pin wins over its resistor; a released pin sits at the resistor level
    always_comb begin
        for (int p = 1; p <= 4; p++) begin
            pin_level[p] = light_oe[p] ? light_out[p] : strap_code[p-1];
        end
    end
    // The polarity pin has no driver besides its resistor
    assign pol_pin = pol_sel;
endmodule // light_strap_partner

// File: test_downstream_port_strap_led_logic.sv
// Self-checking testbench for the downstream port strap and light logic
`timescale 1ns/100ps
module test_downstream_port_strap_led_logic;
    import strap_led_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, pol_sel = 1'b0, pol_pin;
    logic        ce = 1'b1;             // Clock enable, dropped once per test to freeze the pins
    logic [3:0]  addr = 4'h0, strap_code = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:1]  pwr_req = 7'h00, st_req = 7'h00, lt_out, lt_oe, pwr_en, enabled, fixed;
    logic [7:5]  al_req = 3'h0, al_out;
    logic [4:1]  pin_in;
    logic [15:0] seed = 16'h3EFB;       // Fixed start keeps runs repeatable
    int          n_errors = 0, n_compared = 0, cycles = 0;
    always #5 clk = ~clk;
    downstream_port_strap_led_logic uut (.REF_CLK(clk), .RSTN(rstn), .CE(ce), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PORT_POWER_REQ(pwr_req),
        .STATUS_LIGHT_REQ(st_req), .ALERT_LIGHT_REQ(al_req), .POWER_ENABLE_POLARITY_STRAP(pol_pin),
        .PORT_STATUS_LIGHT_IN(pin_in), .PORT_STATUS_LIGHT_OUT(lt_out), .PORT_STATUS_LIGHT_OE(lt_oe),
        .PORT_ALERT_LIGHT_OUT(al_out), .PORT_POWER_ENABLE(pwr_en), .PORT_ENABLED(enabled),
        .PORT_FIXED(fixed));
    light_strap_partner far (.light_out(lt_out[4:1]), .light_oe(lt_oe[4:1]),
        .strap_code(strap_code), .pol_sel(pol_sel), .pin_level(pin_in), .pol_pin(pol_pin));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [7:1] en_of(input logic [1:0] c);
        return 7'h7F >> c;
    endfunction
    function automatic logic [7:1] fix_of(input logic [1:0] c);
        return ~(7'h7F << c);
    endfunction
    // Expected status pin levels; code is {pin4..pin1}
    function automatic logic [7:1] exp_status(input logic [1:0] c, input logic [3:0] code,
                                              input logic [7:1] m, input logic [7:1] r);
        return {~(r[7:5] & m[7:5]), r[4:1] ^ (c[0] ? 4'hF : code)};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so look there
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("read data", exp, rdata & msk);
        // Data must fall back to zero one cycle later
        @(posedge clk);
        #1;
        chk("read idle", 32'h0, rdata);
    endtask
    // Straps change only while the hub has its pins released
    task automatic do_reset(input logic [3:0] code, input logic pol);
        @(posedge clk);
        rstn <= 1'b0;
        strap_code <= code;
        pol_sel <= pol;
        repeat (12) @(posedge clk);
        #1;
        chk("power in reset", {25'h0, {7{~pol}}}, {25'h0, pwr_en});
        chk("drive in reset", 32'h0, {25'h0, lt_oe});
        @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        // Step off the edge so callers see settled outputs
        #1;
    endtask
    // Random requests, with all-on and all-off first as corner cases
    task automatic traffic(input int n, input logic [1:0] c, input logic [3:0] code, input logic pol);
        logic [7:1]  m;
        logic [15:0] r;
        m = c[0] ? 7'h7F : en_of(code[3:2]);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            seed = lfsr(seed);
            r = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed;
            pwr_req <= r[6:0];
            st_req <= r[13:7];
            al_req <= {r[15:14], r[0]};
            @(posedge clk);
            #1;
            chk("power", {25'h0, (pwr_req & m) ^ {7{~pol}}}, {25'h0, pwr_en});
            chk("alert", {29'h0, ~(al_req & m[7:5])}, {29'h0, al_out});
            if (c[0]) chk("light oe", {28'h0, {4{c[1]}}}, {28'h0, lt_oe[4:1]});
            if (c != 2'h1) chk("status", {25'h0, exp_status(c, code, m, st_req)}, {25'h0, lt_out});
        end
    endtask
    task automatic complete_run;
        $display("compared %0d, mismatched %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Runs take a few hundred cycles; this ceiling only catches a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end
    // Every disable and fixed code, both polarities, reset again between passes
    initial begin
        logic [3:0] code;
        logic [31:0] stat;
        for (int k = 0; k < 4; k++) begin
            code = {k[1:0], ~k[1:0]};
            do_reset(code, k[0]);
            chk("enabled", {25'h0, en_of(code[3:2])}, {25'h0, enabled});
            chk("fixed", {25'h0, fix_of(code[1:0])}, {25'h0, fixed});
            stat = {1'b0, fix_of(code[1:0]), 1'b0, en_of(code[3:2]), 11'h0, k[0], code[1:0], code[3:2]};
            rd_chk(REG_STAT_OFS, 32'h7F7F001F, stat);
            traffic(20, 2'h0, code, k[0]);
            wr_reg(REG_CTRL_OFS, 32'h0000_0003);
            traffic(10, 2'h3, code, k[0]);
            wr_reg(REG_CTRL_OFS, 32'h0000_0001);
            traffic(6, 2'h1, code, k[0]);
            // Frozen clock enable: requests flip, the power pins must hold
            @(posedge clk);
            ce <= 1'b0;
            pwr_req <= ~pwr_req;
            repeat (3) @(posedge clk);
            #1;
            chk("frozen power", {25'h0, ~pwr_req ^ {7{~k[0]}}}, {25'h0, pwr_en});
            @(posedge clk);
            ce <= 1'b1;
            wr_reg(4'h8, 32'hFFFF_FFFF);
            rd_chk(4'h8, 32'hFFFF_FFFF, 32'h0);
            rd_chk(REG_CTRL_OFS, 32'h0000_0003, 32'h0000_0001);
            rd_chk(REG_STAT_OFS, 32'h7F7F001F, stat);
            $display("test %0d done, straps %h polarity %b", k, code, k[0]);
        end
        complete_run();
    end
endmodule // test_downstream_port_strap_led_logic
